// file: design/pmic_ctrl_consts.svh
/*
 * Timing and configuration constants for the control pin logic.
 * Assumes a 100 MHz system clock and a 32 kHz internal time base.
 */
`ifndef PMIC_CTRL_CONSTS_SVH
`define PMIC_CTRL_CONSTS_SVH

// Clock and slow time base periods
`define CLK_PERIOD_PS 10000
`define TICK_PERIOD_PS 31250000
`define TICK_CYCLES (`TICK_PERIOD_PS / `CLK_PERIOD_PS)
// Time base ticks in one millisecond
`define TICKS_PER_MS 32

// Width of every persistence counter
`define TMR_W 17

// Interval figures, microseconds
`define DBNC_NONE_US 0
`define DBNC_SHORT_US 31250
`define DBNC_MID_US 125000
`define DBNC_LONG_US 750000
`define LONG_PRESS_US 4000000
`define FAULT_ASSERT_US 1800
`define FAULT_OFF_US 100000
`define GOOD_DELAY_US 2000

// Least times, rounded up to whole ticks
`define US_TO_TICKS(us) (((us) * `TICKS_PER_MS + 999) / 1000)
`define DBNC_SHORT_TICKS `US_TO_TICKS(`DBNC_SHORT_US)
`define DBNC_MID_TICKS `US_TO_TICKS(`DBNC_MID_US)
`define DBNC_LONG_TICKS `US_TO_TICKS(`DBNC_LONG_US)
`define LONG_PRESS_TICKS `US_TO_TICKS(`LONG_PRESS_US)
`define FAULT_ASSERT_TICKS `US_TO_TICKS(`FAULT_ASSERT_US)
// Strictly more than the figure: one tick beyond
`define FAULT_OFF_TICKS (`US_TO_TICKS(`FAULT_OFF_US) + 1)
`define GOOD_DELAY_TICKS `US_TO_TICKS(`GOOD_DELAY_US)

// Filter select codes
`define FSEL_NONE 2'h0
`define FSEL_SHORT 2'h1
`define FSEL_MID 2'h2
`define FSEL_LONG 2'h3

`endif

// file: design/pmic_ctrl_pkg.sv
/*
 * Types shared by the control pin logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pmic_ctrl_pkg;

    // Power state, one-hot
    typedef enum logic [2:0] {
        PWR_OFF = 3'h1,
        PWR_SLEEP = 3'h2,
        PWR_ON = 3'h4
    } power_state_t;

endpackage

// file: design/persist_if.sv
/*
 * Carrier between an owner and one persistence timer.
 * Assumes the owner drives condition and limit on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface persist_if #(parameter int W = 17);
    logic cond; // Condition being timed
    logic [W-1:0] limit; // Ticks the condition must hold
    logic reached; // Condition has held long enough

    modport owner (output cond, output limit, input reached);
    modport timer (input cond, input limit, output reached);
endinterface // persist_if

`default_nettype wire

// file: design/tick_gen.sv
/*
 * Slow time base: one-cycle tick every CYCLES clocks.
 * Assumes a free-running system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tick_gen #(
    parameter int CYCLES = 3125
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic tick
);

    initial begin
        if (CYCLES < 1 || CYCLES > 65535) begin
            $error("tick_gen: CYCLES out of range");
        end
    end

    logic [15:0] div_ff; // Cycle divider

    // ****
    // Divider
    // ****
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_ff <= 16'h0000;
        end else if (div_ff == 16'(CYCLES - 1)) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    // Pulse at the wrap
    assign tick = (div_ff == 16'(CYCLES - 1));

endmodule // tick_gen

`default_nettype wire

// file: design/persist_timer.sv
/*
 * Counts time base ticks while a condition holds.
 * Assumes the owner recomputes condition every cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module persist_timer #(
    parameter int W = 17
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    persist_if.timer p
);

    logic [W-1:0] cnt_ff; // Ticks with condition held

    // ****
    // Counter, restarts when condition drops
    // ****
    always_ff @(posedge clk) begin
        if (!rst_b || !p.cond) begin
            cnt_ff <= '0;
        end else if (tick && cnt_ff < p.limit) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // Held long enough; zero limit passes at once
    assign p.reached = p.cond && (cnt_ff >= p.limit);

endmodule // persist_timer

`default_nettype wire

// file: design/pmic_ctrl.sv
/*
 * Control pin logic of a power management device: turn-on detection,
 * key debounce and flags, standby, supplies-good and fault interrupt.
 * Assumes an external start-up sequencer reporting its last slot,
 * regulator fault detection, and configuration bits held static.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pmic_ctrl_consts.svh"

// Overview of operation
// - Turn-on moves OFF or Sleep to ON
// - Level mode: wake high, no undervoltage
// - Edge mode: wake falling edge, no undervoltage
// - Wake turn-on sets key flag
// - Edge select comes from fixed configuration
// - Sleep regulators stay on into ON
// - Edge mode interrupts on both key edges
// - Rising-edge key debounce always 31.25 ms
// - Filter select sets turn-on debounce
// - Filter select sets falling-edge debounce
// - Key flag holds until cleared or OFF
// - Standby follows the low power request while ON
// - Request polarity chosen by invert bit
// - Timer mode: good 2 ms after sequence
// - Timer mode: good low only at turn-off
// - Supervised mode: good needs fault-free start
// - Supervised mode: 1.8 ms fault drops good
// - Supervised mode: over 100 ms fault shuts off
// - Wake restarts after fault shutdown
// - Supervised mode chosen by configuration bit
// - Unmasked fault drives fault interrupt low
// - Fault interrupt released on write-one clear
// - Edge mode: 4 s low turns off
// - Key level follows the pin undebounced
module pmic_ctrl
    import pmic_ctrl_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int DBNC_SHORT = `DBNC_SHORT_TICKS,
    parameter int DBNC_MID = `DBNC_MID_TICKS,
    parameter int DBNC_LONG = `DBNC_LONG_TICKS,
    parameter int LONG_PRESS = `LONG_PRESS_TICKS,
    parameter int FAULT_ASSERT = `FAULT_ASSERT_TICKS,
    parameter int FAULT_OFF = `FAULT_OFF_TICKS,
    parameter int GOOD_DELAY = `GOOD_DELAY_TICKS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wake_input,
    input wire logic input_undervoltage_level,
    input wire logic low_power_request,
    input wire logic regulator_fault,
    input wire logic turn_on_edge_select,
    input wire logic supervised_good_enable,
    input wire logic low_power_polarity_invert,
    input wire logic [1:0] power_key_filter_sel,
    input wire logic sleep_select,
    input wire logic sequence_done,
    input wire logic key_irq_clear,
    input wire logic fault_irq_clear,
    input wire logic fault_irq_mask,
    output pmic_ctrl_pkg::power_state_t power_state,
    output logic standby_active,
    output logic sequence_start,
    output logic keep_sleep_regulators,
    output logic power_key_irq_flag,
    output logic power_key_level,
    output logic fault_irq_flag,
    output logic supplies_good_n_out,
    output logic supplies_good_n_oe_b,
    output logic fault_irq_n_out,
    output logic fault_irq_n_oe_b
);
    import pmic_ctrl_pkg::*;

    // ****
    // Elaboration checks
    // ****
    localparam int TMAX = (1 << `TMR_W) - 1;
    initial begin
        if (DBNC_SHORT > TMAX || DBNC_MID > TMAX || DBNC_LONG > TMAX ||
            LONG_PRESS > TMAX || FAULT_OFF > TMAX || GOOD_DELAY > TMAX ||
            FAULT_ASSERT > TMAX || TICK_CYCLES < 1) begin
            $error("pmic_ctrl: count parameter out of range");
        end
    end

    // Timer slots
    localparam int T_TON = 0; // Turn-on qualify
    localparam int T_KFALL = 1; // Key falling edge
    localparam int T_KRISE = 2; // Key rising edge
    localparam int T_LONG = 3; // Long press
    localparam int T_FASS = 4; // Fault to good low
    localparam int T_FOFF = 5; // Fault to shutdown
    localparam int T_GOOD = 6; // Sequence end to good
    localparam int NTMR = 7;

    logic tick; // Slow time base pulse
    logic [3:0] sync_a_ff; // First synchroniser stage
    logic [3:0] sync_b_ff; // Second synchroniser stage
    logic wake_s; // Synchronised key pin
    logic uv_s; // Synchronised undervoltage level
    logic lpr_s; // Synchronised low power request
    logic flt_s; // Synchronised regulator fault
    logic flt_q_ff; // Fault of last cycle
    power_state_t state_ff; // Power state
    power_state_t nxt_state; // Next power state
    logic armed_ff; // Key seen high since last turn-on or leaving ON
    logic turn_on; // Turn-on event this cycle
    logic off_req; // Key turn-off request
    logic fault_shutdown; // Fault persisted too long
    logic kfall_q_ff; // Falling debounce reached last cycle
    logic krise_q_ff; // Rising debounce reached last cycle
    logic key_event; // Debounced key edge
    logic key_flag_ff; // Key interrupt flag
    logic key_lvl_ff; // Key level sense
    logic flt_flag_ff; // Fault interrupt flag
    logic irq_drive_ff; // Fault pin driven low
    logic seq_done_ff; // Sequencer finished this start
    logic fault_seen_ff; // Fault during start or while on
    logic good_ff; // Supplies good released
    logic low_power_request_ff; // Standby mode
    logic start_ff; // Sequence start pulse
    logic from_sleep_ff; // Start came out of Sleep

    persist_if #(.W(`TMR_W)) tp[NTMR] ();

    // ****
    // Time base and timers
    // ****
    tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick)
    );

    // One persistence counter per interval
    genvar gi;
    generate
        for (gi = 0; gi < NTMR; gi++) begin : g_tmr
            persist_timer #(.W(`TMR_W)) u_tmr (
                .clk(clk),
                .rst_b(rst_b),
                .tick(tick),
                .p(tp[gi])
            );
        end
    endgenerate

    // Turn-on debounce per filter select
    function automatic logic [`TMR_W-1:0] ton_limit(input logic [1:0] s);
        unique case (s)
            `FSEL_NONE: ton_limit = '0;
            `FSEL_SHORT: ton_limit = `TMR_W'(DBNC_SHORT);
            `FSEL_MID: ton_limit = `TMR_W'(DBNC_MID);
            `FSEL_LONG: ton_limit = `TMR_W'(DBNC_LONG);
        endcase
    endfunction

    // Falling-edge interrupt debounce per filter select
    function automatic logic [`TMR_W-1:0] fall_limit(input logic [1:0] s);
        unique case (s)
            `FSEL_NONE, `FSEL_SHORT: fall_limit = `TMR_W'(DBNC_SHORT);
            `FSEL_MID: fall_limit = `TMR_W'(DBNC_MID);
            `FSEL_LONG: fall_limit = `TMR_W'(DBNC_LONG);
        endcase
    endfunction

    // ****
    // Pin synchronisers
    // ****
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_a_ff <= 4'h0;
            sync_b_ff <= 4'h0;
        end else begin
            sync_a_ff <= {regulator_fault, low_power_request,
                          input_undervoltage_level, wake_input};
            sync_b_ff <= sync_a_ff;
        end
    end

    assign wake_s = sync_b_ff[0];
    assign uv_s = sync_b_ff[1];
    assign lpr_s = sync_b_ff[2];
    assign flt_s = sync_b_ff[3];

    // ****
    // Timer conditions, all on the slow base
    // ****
    // Level mode: wake high; edge mode: armed key held low
    assign tp[T_TON].cond = (state_ff != PWR_ON) && !uv_s &&
        (turn_on_edge_select ? (armed_ff && !wake_s) : wake_s);
    assign tp[T_TON].limit = ton_limit(power_key_filter_sel);
    assign tp[T_KFALL].cond = turn_on_edge_select && !wake_s;
    assign tp[T_KFALL].limit = fall_limit(power_key_filter_sel);
    assign tp[T_KRISE].cond = turn_on_edge_select && wake_s;
    assign tp[T_KRISE].limit = `TMR_W'(DBNC_SHORT);
    assign tp[T_LONG].cond = turn_on_edge_select &&
        (state_ff == PWR_ON) && !wake_s;
    assign tp[T_LONG].limit = `TMR_W'(LONG_PRESS);
    assign tp[T_FASS].cond = supervised_good_enable &&
        (state_ff == PWR_ON) && flt_s;
    assign tp[T_FASS].limit = `TMR_W'(FAULT_ASSERT);
    assign tp[T_FOFF].cond = supervised_good_enable &&
        (state_ff == PWR_ON) && flt_s;
    assign tp[T_FOFF].limit = `TMR_W'(FAULT_OFF);
    assign tp[T_GOOD].cond = (state_ff == PWR_ON) && seq_done_ff;
    assign tp[T_GOOD].limit = `TMR_W'(GOOD_DELAY);

    // ****
    // Events
    // ****
    assign turn_on = tp[T_TON].reached;
    assign off_req = turn_on_edge_select ? tp[T_LONG].reached : !wake_s;
    assign fault_shutdown = tp[T_FOFF].reached;
    assign key_event = (tp[T_KFALL].reached && !kfall_q_ff) ||
        (tp[T_KRISE].reached && !krise_q_ff);

    // ****
    // Power state
    // ****
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PWR_OFF, PWR_SLEEP: begin
                if (turn_on) begin
                    nxt_state = PWR_ON;
                end
            end
            PWR_ON: begin
                if (fault_shutdown) begin
                    nxt_state = PWR_OFF;
                end else if (off_req) begin
                    nxt_state = sleep_select ? PWR_SLEEP : PWR_OFF;
                end
            end
            default: begin
                nxt_state = PWR_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= PWR_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Edge arming: a new press needs the key released first
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            armed_ff <= 1'b0;
        end else if (turn_on || (state_ff == PWR_ON && nxt_state != PWR_ON)) begin
            // Leaving ON disarms too, so a held key cannot restart
            armed_ff <= 1'b0;
        end else if (wake_s) begin
            armed_ff <= 1'b1;
        end
    end

    // ****
    // Sequencer handshake
    // ****
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            start_ff <= 1'b0;
            from_sleep_ff <= 1'b0;
        end else begin
            start_ff <= turn_on;
            if (turn_on) begin
                // Sleep regulators kept, not re-sequenced
                from_sleep_ff <= (state_ff == PWR_SLEEP);
            end
        end
    end

    // Last sequenced regulator enabled for this start
    always_ff @(posedge clk) begin
        if (!rst_b || turn_on || state_ff != PWR_ON) begin
            seq_done_ff <= 1'b0;
        end else if (sequence_done) begin
            seq_done_ff <= 1'b1;
        end
    end

    // ****
    // Key flags
    // ****
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            kfall_q_ff <= 1'b0;
            krise_q_ff <= 1'b0;
            key_lvl_ff <= 1'b0;
        end else begin
            kfall_q_ff <= tp[T_KFALL].reached;
            krise_q_ff <= tp[T_KRISE].reached;
            key_lvl_ff <= wake_s;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            key_flag_ff <= 1'b0;
        end else if (turn_on || (key_event && state_ff != PWR_OFF)) begin
            key_flag_ff <= 1'b1;
        end else if (key_irq_clear || state_ff == PWR_OFF) begin
            key_flag_ff <= 1'b0;
        end
    end

    // ****
    // Fault interrupt
    // ****
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flt_q_ff <= 1'b0;
            flt_flag_ff <= 1'b0;
        end else begin
            flt_q_ff <= flt_s;
            if (flt_s && !flt_q_ff) begin
                flt_flag_ff <= 1'b1;
            end else if (fault_irq_clear) begin
                flt_flag_ff <= 1'b0;
            end
        end
    end

    // Pin driven while flag set and unmasked
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_drive_ff <= 1'b0;
        end else begin
            irq_drive_ff <= flt_flag_ff && !fault_irq_mask;
        end
    end

    // ****
    // Supplies good
    // ****
    // Faults in start-up or held on bar the release
    always_ff @(posedge clk) begin
        if (!rst_b || turn_on) begin
            fault_seen_ff <= 1'b0;
        end else if (state_ff == PWR_ON &&
                     ((flt_s && !good_ff) || tp[T_FASS].reached)) begin
            fault_seen_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            good_ff <= 1'b0;
        end else if (nxt_state != PWR_ON) begin
            good_ff <= 1'b0;
        end else if (tp[T_FASS].reached) begin
            good_ff <= 1'b0;
        end else if (tp[T_GOOD].reached &&
                     !(supervised_good_enable && fault_seen_ff)) begin
            good_ff <= 1'b1;
        end
    end

    // ****
    // Standby
    // ****
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            low_power_request_ff <= 1'b0;
        end else begin
            low_power_request_ff <= (state_ff == PWR_ON) &&
                (lpr_s ^ low_power_polarity_invert);
        end
    end

    // ****
    // Outputs
    // ****
    assign power_state = state_ff;
    assign standby_active = low_power_request_ff;
    assign sequence_start = start_ff;
    assign keep_sleep_regulators = from_sleep_ff;
    assign power_key_irq_flag = key_flag_ff;
    assign power_key_level = key_lvl_ff;
    assign fault_irq_flag = flt_flag_ff;
    // Open drain: only ever pulls low
    assign supplies_good_n_out = 1'b0;
    assign supplies_good_n_oe_b = good_ff;
    assign fault_irq_n_out = 1'b0;
    assign fault_irq_n_oe_b = !irq_drive_ff;

endmodule // pmic_ctrl

`default_nettype wire

// file: tb/host_model.sv
/* Host side model: answers a start pulse with sequence_done.
   Assumes one system clock; slow picks the long answer. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic sequence_start,
    output logic sequence_done
);
    int cnt = -1; // Cycles until done, -1 idle
    initial sequence_done = 1'b0;
    // Count down after each start, then pulse done once
    always @(posedge clk) begin
        sequence_done <= 1'b0;
        if (sequence_start) begin
            cnt <= slow ? 15 : 2; // Slow or prompt sequencer
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            sequence_done <= 1'b1;
            cnt <= -1;
        end
    end
endmodule // host_model
`default_nettype wire

// file: tb/ctrl_asserts.sv
/* Port checks on the control pin logic.
   Assumes bind onto pmic_ctrl, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module ctrl_asserts
    import pmic_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wake_input,
    input wire logic input_undervoltage_level,
    input wire logic low_power_request,
    input wire logic low_power_polarity_invert,
    input wire logic turn_on_edge_select,
    input wire logic fault_irq_mask,
    input wire pmic_ctrl_pkg::power_state_t power_state,
    input wire logic standby_active,
    input wire logic sequence_start,
    input wire logic power_key_irq_flag,
    input wire logic power_key_level,
    input wire logic fault_irq_flag,
    input wire logic supplies_good_n_out,
    input wire logic supplies_good_n_oe_b,
    input wire logic fault_irq_n_out,
    input wire logic fault_irq_n_oe_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_start_on_flag: assert property (
        $rose(sequence_start) |-> power_state == PWR_ON && power_key_irq_flag)
        else $error("start without flag");
    chk_off_key_clear: assert property (
        (power_state == PWR_OFF) [*3] |-> !power_key_irq_flag)
        else $error("key flag held in OFF");
    chk_off_good_low: assert property (
        (power_state == PWR_OFF) [*2] |-> !supplies_good_n_oe_b)
        else $error("good released in OFF");
    chk_fault_pin: assert property (
        fault_irq_n_oe_b == !$past(fault_irq_flag && !fault_irq_mask))
        else $error("fault pin wrong");
    chk_pins_low: assert property (
        !supplies_good_n_out && !fault_irq_n_out)
        else $error("open drain data not low");
    chk_standby_on: assert property (
        (power_state == PWR_ON && (low_power_request
        ^ low_power_polarity_invert)) [*4] |-> standby_active)
        else $error("standby not entered");
    chk_standby_off: assert property (
        !(low_power_request ^ low_power_polarity_invert) [*4]
        |-> !standby_active)
        else $error("standby not left");
    chk_level_off: assert property (
        (!turn_on_edge_select && !wake_input) [*5] |-> power_state != PWR_ON)
        else $error("on with wake low");
    chk_uv_block: assert property (
        input_undervoltage_level [*4] |-> !$rose(power_state == PWR_ON))
        else $error("turn-on under undervoltage");
    chk_key_level: assert property (
        $stable(wake_input) [*4] |-> power_key_level == wake_input)
        else $error("key level wrong");
endmodule // ctrl_asserts
`default_nettype wire

// file: tb/tb.sv
/* Self-checking bench for the control pin logic.
   Assumes shortened tick and interval parameters. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pmic_ctrl_pkg::*;
    localparam int T = 4; // Clocks per tick
    logic clk = 0, rst_b = 0, wake_input = 0, input_undervoltage_level = 0;
    logic low_power_request = 0, regulator_fault = 0, slow = 0;
    logic turn_on_edge_select = 0, supervised_good_enable = 0;
    logic low_power_polarity_invert = 0, sleep_select = 0;
    logic key_irq_clear = 0, fault_irq_clear = 0, fault_irq_mask = 0;
    logic [1:0] power_key_filter_sel = 2'h0;
    logic sequence_done, sequence_start, standby_active;
    logic keep_sleep_regulators, power_key_irq_flag, power_key_level;
    logic fault_irq_flag, supplies_good_n_out, supplies_good_n_oe_b;
    logic fault_irq_n_out, fault_irq_n_oe_b;
    power_state_t power_state;
    int mismatches = 0, n_checks = 0, cycles = 0;
    int ton[4] = '{0, 2, 3, 4}; // Turn-on debounce, ticks
    int tfa[4] = '{2, 2, 3, 4}; // Falling interrupt debounce, ticks
    always #5 clk = ~clk;
    pmic_ctrl #(.TICK_CYCLES(T), .DBNC_SHORT(2), .DBNC_MID(3),
        .DBNC_LONG(4), .LONG_PRESS(6), .FAULT_ASSERT(2), .FAULT_OFF(5),
        .GOOD_DELAY(2)) uut (.*);
    host_model host (.clk(clk), .slow(slow),
        .sequence_start(sequence_start), .sequence_done(sequence_done));
    // ****
    // Compare and wait helpers
    // ****
    task automatic cmp_bit(string nm, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic cmp_rng(string nm, int lo, int hi, int g);
        n_checks++;
        if (g < lo || g > hi) begin
            mismatches++;
            $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask
    function automatic logic hit(int w);
        case (w)
            0: return power_state === PWR_ON;
            1: return power_key_irq_flag === 1'b1;
            2: return power_state === PWR_OFF;
            3: return supplies_good_n_oe_b === 1'b1;
            5: return supplies_good_n_oe_b === 1'b0;
            default: return power_state === PWR_SLEEP;
        endcase
    endfunction
    // Cycles until condition w, against a tick window
    task automatic meas(int w, int lo_t, int hi_t, string nm);
        int n;
        int hi;
        n = 0;
        hi = hi_t * T + 10;
        #1;
        while (!hit(w) && n <= hi) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp_rng(nm, lo_t > 0 ? (lo_t - 1) * T : 0, hi, n);
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic clr_key;
        @(posedge clk) key_irq_clear <= 1'b1;
        @(posedge clk) key_irq_clear <= 1'b0;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test;
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        cyc(1);
        cmp_bit("reset off", 1, hit(2));
        cmp_bit("reset good", 0, supplies_good_n_oe_b);
        cmp_bit("reset irq pin", 1, fault_irq_n_oe_b);
        // Level mode, undervoltage first
        @(posedge clk) input_undervoltage_level <= 1'b1;
        @(posedge clk) wake_input <= 1'b1;
        cyc(12);
        cmp_bit("uv block", 1, hit(2));
        @(posedge clk) input_undervoltage_level <= 1'b0;
        meas(0, 0, 0, "level on");
        cmp_bit("key flag", 1, power_key_irq_flag);
        cmp_bit("key level", 1, power_key_level);
        meas(3, 2, 2, "good release");
        @(posedge clk) low_power_request <= 1'b1;
        cyc(5);
        cmp_bit("low_power_request hi", 1, standby_active);
        @(posedge clk) low_power_polarity_invert <= 1'b1;
        cyc(5);
        cmp_bit("low_power_request inv", 0, standby_active);
        @(posedge clk) low_power_request <= 1'b0;
        cyc(5);
        cmp_bit("low_power_request lo", 1, standby_active);
        @(posedge clk) low_power_polarity_invert <= 1'b0;
        clr_key;
        cyc(1);
        cmp_bit("key clear", 0, power_key_irq_flag);
        @(posedge clk) wake_input <= 1'b0;
        meas(2, 0, 0, "level off");
        cmp_bit("good off", 0, supplies_good_n_oe_b);
        // Sleep and restart from Sleep
        @(posedge clk) sleep_select <= 1'b1;
        @(posedge clk) wake_input <= 1'b1;
        meas(0, 0, 0, "on");
        @(posedge clk) wake_input <= 1'b0;
        meas(6, 0, 0, "sleep");
        @(posedge clk) slow <= 1'b1;
        @(posedge clk) wake_input <= 1'b1;
        meas(0, 0, 0, "sleep wake");
        cyc(2);
        cmp_bit("keep regs", 1, keep_sleep_regulators);
        @(posedge clk) sleep_select <= 1'b0;
        @(posedge clk) wake_input <= 1'b0;
        meas(2, 0, 0, "off");
        // Edge mode over every filter code
        @(posedge clk) turn_on_edge_select <= 1'b1;
        @(posedge clk) wake_input <= 1'b1;
        cyc(14);
        for (int s = 0; s < 4; s++) begin
            @(posedge clk) power_key_filter_sel <= 2'(s);
            @(posedge clk) wake_input <= 1'b0;
            meas(0, ton[s], ton[s], "edge on");
            @(posedge clk) wake_input <= 1'b1;
            cyc(14);
            clr_key;
            @(posedge clk) wake_input <= 1'b0;
            meas(1, tfa[s], tfa[s], "fall irq");
            @(posedge clk) begin
                wake_input <= 1'b1;
                key_irq_clear <= 1'b1;
            end
            @(posedge clk) key_irq_clear <= 1'b0;
            meas(1, 2, 2, "rise irq");
            @(posedge clk) wake_input <= 1'b0;
            meas(2, 6, 6, "long press");
            @(posedge clk) wake_input <= 1'b1;
            cyc(14);
        end
        // Supervised good with a lasting fault
        @(posedge clk) begin
            supervised_good_enable <= 1'b1;
            power_key_filter_sel <= 2'h0;
            slow <= 1'b0;
        end
        @(posedge clk) wake_input <= 1'b0;
        meas(0, 0, 0, "sup on");
        @(posedge clk) wake_input <= 1'b1;
        meas(3, 2, 2, "sup good");
        @(posedge clk) regulator_fault <= 1'b1;
        meas(5, 2, 2, "fault good");
        cmp_bit("irq pin", 0, fault_irq_n_oe_b);
        meas(2, 3, 3, "fault off");
        cyc(14);
        @(posedge clk) wake_input <= 1'b0;
        meas(0, 0, 0, "restart");
        @(posedge clk) wake_input <= 1'b1;
        cyc(14);
        cmp_bit("no good", 0, supplies_good_n_oe_b);
        meas(2, 0, 5, "refault off");
        @(posedge clk) begin
            regulator_fault <= 1'b0;
            fault_irq_mask <= 1'b1;
        end
        cyc(3);
        cmp_bit("masked pin", 1, fault_irq_n_oe_b);
        @(posedge clk) fault_irq_mask <= 1'b0;
        cyc(3);
        cmp_bit("pin held", 0, fault_irq_n_oe_b);
        @(posedge clk) fault_irq_clear <= 1'b1;
        @(posedge clk) fault_irq_clear <= 1'b0;
        cyc(2);
        cmp_bit("pin free", 1, fault_irq_n_oe_b);
        finish_test;
    end
endmodule // tb
bind pmic_ctrl ctrl_asserts chk (.*);
`default_nettype wire
